// *** src/irq_vec.sv ***
// Purpose: Latches interrupt requests, gates them and vectors the core.
// Assumes: Peripheral events and core signals share pclk; pins are asynchronous.
// Notes:   APB slave with zero wait states; pready is tied high.
//          Register data sits in the low byte of each word, upper bits read zero.
//          A return from interrupt leaves the global enable cleared.
// Behaviour
// RULE_01: Source event sets flag regardless of enable.
// RULE_02: Disabled flag stays recorded, never vectors.
// RULE_03: Cleared global enable suppresses every vector jump.
// RULE_04: Accept pushes next PC, loads vector.
// RULE_05: Return instruction pops saved PC.
// RULE_06: Service start clears global enable.
// RULE_07: Blocked requests still set and keep flags.
// RULE_08: Full stack holds off acknowledge.
// RULE_09: Simultaneous requests served by fixed priority.
// RULE_10: Any newly set flag wakes core.
// RULE_11: Software presets flag to avoid wake.
// RULE_12: Pin edge of chosen type sets flag.
// RULE_13: Pin vectors only with global and pin enable.
// RULE_14: Pin needs enable, function select, input direction.
// RULE_15: Pin service clears its flag and global enable.
// RULE_16: Pull-up selection stays valid on interrupt pins.
// RULE_17: Edge select offers rising, falling or both.
// RULE_18: Edge select can disable pin function.
// RULE_19: Group 0 register field layout.
// RULE_20: Group 1 register layout, reset zero.
// RULE_21: Group 2 register layout, one means active.
// RULE_22: Group 3 register layout, bits 7,3 zero.
// RULE_23: Member flag set sets group flag.
// RULE_24: Group service clears only group flag.
// RULE_25: Pin edges from synchronised sample comparison.
// RULE_26: Lower vector address wins priority.
//
// Our own choices: the APB interface to the registers and the register addresses.
`timescale 1ns/1ps
module irq_vec
  import irq_vec_pkg::*;
#(
  parameter int              ADDR_W   = 8,
  parameter logic [PC_W-1:0] VEC_BASE = 13'h0004,
  parameter logic [PC_W-1:0] VEC_STEP = 13'h0004
) (
  input  wire logic                pclk,
  input  wire logic                presetn,
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [ADDR_W-1:0]   paddr,
  input  wire logic [31:0]         pwdata,
  output logic [31:0]              prdata,
  output logic                     pready,
  output logic                     pslverr,
  input  wire logic [N_PINS-1:0]   external_interrupt_pins,
  input  wire logic [N_PINS-1:0]   pin_func_is_irq,
  input  wire logic [N_PINS-1:0]   pin_dir_is_input,
  input  wire logic [N_PINS-1:0]   pin_pullup_select,
  output logic [N_PINS-1:0]        pin_pullup_enable,
  input  wire logic [3*N_GRPS-1:0] member_events,
  input  core_in_t                 core_in,
  output core_out_t                core_out
);

  typedef enum logic { ST_IDLE, ST_ENTER } svc_state_t;

  // Internal register numbers; 0 to 3 must stay the group registers.
  localparam logic [3:0] IDX_GRP0  = 4'h0;
  localparam logic [3:0] IDX_GRP1  = 4'h1;
  localparam logic [3:0] IDX_GRP2  = 4'h2;
  localparam logic [3:0] IDX_GRP3  = 4'h3;
  localparam logic [3:0] IDX_CTRL  = 4'h4;
  localparam logic [3:0] IDX_PFLAG = 4'h5;
  localparam logic [3:0] IDX_EDGE  = 4'h6;
  localparam logic [3:0] IDX_GFLAG = 4'h7;
  localparam logic [3:0] IDX_STAT  = 4'h8;
  localparam logic [3:0] IDX_NONE  = 4'hf;

  function automatic logic [3:0] reg_index(input logic [ADDR_W-1:0] a);
    case (a[7:0])
      OFF_GRP0:  reg_index = IDX_GRP0;
      OFF_GRP1:  reg_index = IDX_GRP1;
      OFF_GRP2:  reg_index = IDX_GRP2;
      OFF_GRP3:  reg_index = IDX_GRP3;
      OFF_CTRL:  reg_index = IDX_CTRL;
      OFF_PFLAG: reg_index = IDX_PFLAG;
      OFF_EDGE:  reg_index = IDX_EDGE;
      OFF_GFLAG: reg_index = IDX_GFLAG;
      OFF_STAT:  reg_index = IDX_STAT;
      default:   reg_index = IDX_NONE;
    endcase
  endfunction : reg_index

  // Picks the edge kind that the select field asks for.
  function automatic logic edge_hit(input logic [1:0] sel,
                                    input logic       rise,
                                    input logic       fall);
    case (sel)
      EDGE_RISE: edge_hit = rise;                              // [RULE_17]
      EDGE_FALL: edge_hit = fall;                              // [RULE_17]
      EDGE_BOTH: edge_hit = rise || fall;                      // [RULE_17]
      default:   edge_hit = 1'b0;                              // [RULE_18]
    endcase
  endfunction : edge_hit

  // Vector address of a priority index; a lower index sits at a lower address.
  function automatic logic [PC_W-1:0] vector_addr(input logic [2:0] idx);
    vector_addr = PC_W'(VEC_BASE + VEC_STEP * PC_W'(idx));     // [RULE_26]
  endfunction : vector_addr

  // Lowest set index; an empty vector gives zero, so callers check pending first.
  function automatic logic [2:0] first_set(input logic [N_SRC-1:0] v);
    first_set = 3'h0;
    for (int i = N_SRC - 1; i >= 0; i--) begin
      if (v[i]) begin
        first_set = 3'(i);
      end
    end
  endfunction : first_set

  // Pin sampling.
  logic [N_PINS-1:0] sync1_q, sync1_d;
  logic [N_PINS-1:0] sync2_q, sync2_d;
  logic [N_PINS-1:0] prev_q, prev_d;
  logic [N_PINS-1:0] pin_evt;
  logic [N_PINS-1:0] pullup_q, pullup_d;

  // Register state.
  logic [7:0]        grp_q [N_GRPS];
  logic [7:0]        grp_d [N_GRPS];
  logic              gie_q, gie_d;
  logic [N_PINS-1:0] pen_q, pen_d;
  logic [N_PINS-1:0] pflag_q, pflag_d;
  logic [7:0]        edge_q, edge_d;
  logic [N_GRPS-1:0] gflag_q, gflag_d;
  logic [N_GRPS-1:0] gen_q, gen_d;
  logic [31:0]       rdata_q, rdata_d;
  logic              wake_q, wake_d;

  // Service state.
  svc_state_t        state_q, state_d;
  logic [2:0]        src_q, src_d;
  logic [PC_W-1:0]   vec_q, vec_d;
  logic [PC_W-1:0]   ret_q, ret_d;
  logic              pop_q, pop_d;

  logic [N_SRC-1:0]  pending;
  logic [2:0]        winner;
  logic              take_now;
  logic              wr_acc;
  logic [3:0]        widx;
  logic [3:0]        ridx;
  logic [7:0]        wbyte;
  logic              unmapped;
  logic              any_pending;
  logic              in_service;
  logic [3*N_GRPS-1:0] member_new;
  logic [N_PINS-1:0] pin_new;
  logic [N_GRPS-1:0] grp_new;

  assign pready  = 1'b1;
  // Unmapped addresses still complete, with an error, so the bus never hangs.
  assign unmapped = (reg_index(paddr) == IDX_NONE);
  assign pslverr = psel && penable && unmapped;
  assign prdata  = rdata_q;
  assign wr_acc  = psel && penable && pwrite;
  assign widx    = reg_index(paddr);
  assign ridx    = reg_index(paddr);
  assign wbyte   = pwdata[7:0];

  // The first stage may go metastable, so only the second stage feeds logic.
  // Only the second stage and the previous sample are compared.
  always_comb begin
    sync1_d  = external_interrupt_pins;
    sync2_d  = sync1_q;
    prev_d   = sync2_q;                                        // [RULE_25]
    pullup_d = pin_pullup_select;                              // [RULE_16]
    for (int i = 0; i < N_PINS; i++) begin
      logic rise;
      logic fall;
      logic active;
      logic [1:0] sel;
      rise   = 1'b0;
      fall   = 1'b0;
      active = 1'b0;
      sel    = edge_q[2*i +: 2];
      rise   = sync2_q[i] && !prev_q[i];                       // [RULE_25]
      fall   = !sync2_q[i] && prev_q[i];
      active = pin_func_is_irq[i] && pin_dir_is_input[i];      // [RULE_14]
      pin_evt[i] = active && edge_hit(sel, rise, fall);      // [RULE_12]
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_q  <= '0;
      sync2_q  <= '0;
      prev_q   <= '0;
      pullup_q <= '0;
    end else begin
      sync1_q  <= sync1_d;
      sync2_q  <= sync2_d;
      prev_q   <= prev_d;
      pullup_q <= pullup_d;
    end
  end

  // The pull-up choice passes through untouched while a pin serves as an interrupt.
  assign pin_pullup_enable = pullup_q;

  // Pins take vectors 0-3, groups 4-7; the lowest index wins.
  assign pending  = {gflag_q & gen_q, pflag_q & pen_q};        // [RULE_02] [RULE_13]
  assign winner   = first_set(pending);                         // [RULE_09] [RULE_26]
  assign take_now = (state_q == ST_IDLE) && gie_q              // [RULE_03]
                    && (|pending) && !core_in.stack_full;      // [RULE_08]
  assign any_pending = |pending;
  assign in_service  = (state_q == ST_ENTER);

  always_comb begin
    logic [2:0]       mset;
    mset    = '0;
    grp_d   = grp_q;
    gie_d   = gie_q;
    pen_d   = pen_q;
    pflag_d = pflag_q;
    edge_d  = edge_q;
    gflag_d = gflag_q;
    gen_d   = gen_q;
    rdata_d = rdata_q;
    // Read data is captured in the setup cycle so it is stable in access.
    if (psel && !penable && !pwrite) begin
      rdata_d = '0;
      case (ridx)
        IDX_GRP0, IDX_GRP1, IDX_GRP2, IDX_GRP3: begin
          rdata_d[7:0] = grp_q[ridx[1:0]] & GRP_MASK;
        end
        IDX_CTRL: begin
          rdata_d[CTRL_GIE_BIT] = gie_q;
          rdata_d[CTRL_PEN_LSB +: N_PINS] = pen_q;
        end
        IDX_PFLAG: rdata_d[N_PINS-1:0] = pflag_q;
        IDX_EDGE:  rdata_d[7:0] = edge_q;
        IDX_GFLAG: rdata_d[7:0] = {gen_q, gflag_q};
        IDX_STAT: begin
          rdata_d[2:0] = winner;
          rdata_d[4]   = any_pending;
          rdata_d[5]   = in_service;
        end
        default: rdata_d = '0;
      endcase
    end

    if (wr_acc) begin
      case (widx)
        IDX_GRP0, IDX_GRP1, IDX_GRP2, IDX_GRP3: begin
          grp_d[widx[1:0]] = wbyte & GRP_MASK;                 // [RULE_19] [RULE_22]
        end
        IDX_CTRL: begin
          gie_d = wbyte[CTRL_GIE_BIT];
          pen_d = wbyte[CTRL_PEN_LSB +: N_PINS];
        end
        IDX_PFLAG: pflag_d = wbyte[N_PINS-1:0];
        IDX_EDGE:  edge_d = wbyte;
        IDX_GFLAG: begin
          gflag_d = wbyte[N_GRPS-1:0];
          gen_d   = wbyte[GFLAG_EN_LSB +: N_GRPS];
        end
        default: ;
      endcase
    end

    // Hardware clear on service; member flags are left to software.
    // A software write of the global enable in the decision cycle loses to it.
    if (take_now) begin
      gie_d = 1'b0;                                            // [RULE_06] [RULE_15]
      if (winner < 3'(N_PINS)) begin
        pflag_d[winner[1:0]] = 1'b0;                           // [RULE_15]
      end else begin
        gflag_d[winner[1:0]] = 1'b0;                           // [RULE_24]
      end
    end
    // Events come last so a set in the clearing cycle is never lost.
    for (int g = 0; g < N_GRPS; g++) begin
      mset = member_events[3*g +: 3];
      grp_d[g][GRP_FLAG_LSB +: 3] = grp_d[g][GRP_FLAG_LSB +: 3] | mset; // [RULE_01] [RULE_07]
      if (|(mset & grp_q[g][GRP_EN_LSB +: 3])) begin
        gflag_d[g] = 1'b1;                                     // [RULE_23]
      end
    end
    pflag_d = pflag_d | pin_evt;                               // [RULE_12] [RULE_07]
  end

  // Only hardware events, or a software write of a group flag, that turn a clear flag on count, so a flag that
  // software presets before sleep cannot wake the core again.
  always_comb begin
    member_new = '0;
    for (int g = 0; g < N_GRPS; g++) begin
      member_new[3*g +: 3] = member_events[3*g +: 3] & ~grp_q[g][GRP_FLAG_LSB +: 3];
    end
    pin_new = pin_evt & ~pflag_q;
    grp_new = gflag_d & ~gflag_q;
    wake_d  = core_in.sleeping && (|{member_new, pin_new, grp_new}); // [RULE_10]
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int g = 0; g < N_GRPS; g++) begin
        grp_q[g] <= RST_BYTE;                                  // [RULE_20]
      end
      gie_q   <= 1'b0;
      pen_q   <= '0;
      pflag_q <= '0;
      edge_q  <= RST_BYTE;
      gflag_q <= '0;
      gen_q   <= '0;
      rdata_q <= '0;
      wake_q  <= 1'b0;
    end else begin
      grp_q   <= grp_d;                                        // [RULE_21]
      gie_q   <= gie_d;
      pen_q   <= pen_d;
      pflag_q <= pflag_d;
      edge_q  <= edge_d;
      gflag_q <= gflag_d;
      gen_q   <= gen_d;
      rdata_q <= rdata_d;
      wake_q  <= wake_d;
    end
  end

  // The vector is loaded one cycle after the decision, from flops.
  // The return address is the next pc that the core shows at the decision edge.
  always_comb begin
    state_d = state_q;
    src_d   = src_q;
    vec_d   = vec_q;
    ret_d   = ret_q;
    pop_d   = core_in.return_from_interrupt_instruction;                                    // [RULE_05]
    case (state_q)
      ST_IDLE: begin
        if (take_now) begin
          state_d = ST_ENTER;
          src_d   = winner;
          vec_d   = vector_addr(winner);                       // [RULE_04] [RULE_26]
          ret_d   = core_in.pc_next;                           // [RULE_04]
        end
      end
      ST_ENTER: state_d = ST_IDLE;
      default:  state_d = ST_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= ST_IDLE;
      src_q   <= '0;
      vec_q   <= '0;
      ret_q   <= '0;
      pop_q   <= 1'b0;
    end else begin
      state_q <= state_d;
      src_q   <= src_d;
      vec_q   <= vec_d;
      ret_q   <= ret_d;
      pop_q   <= pop_d;
    end
  end

  always_comb begin
    core_out.take      = (state_q == ST_ENTER);
    core_out.push      = (state_q == ST_ENTER);                // [RULE_04]
    core_out.push_data = ret_q;
    core_out.load_pc   = vec_q;
    core_out.pop       = pop_q;                                // [RULE_05]
    core_out.wake      = wake_q;
  end

endmodule : irq_vec

// *** src/irq_vec_pkg.sv ***
// Purpose: Shared constants and carriers for the interrupt request and vectoring block.
// Assumes: One clock domain, APB register access, 32-bit data words.
// Notes:   Register data is 8 bits wide and sits in the low byte of each word.
package irq_vec_pkg;

  localparam int N_PINS = 4;
  localparam int N_GRPS = 4;
  localparam int N_SRC  = 8;
  localparam int PC_W   = 13;

  localparam logic [7:0] OFF_GRP0  = 8'h00;
  localparam logic [7:0] OFF_GRP1  = 8'h04;
  localparam logic [7:0] OFF_GRP2  = 8'h08;
  localparam logic [7:0] OFF_GRP3  = 8'h0c;
  localparam logic [7:0] OFF_CTRL  = 8'h10;
  localparam logic [7:0] OFF_PFLAG = 8'h14;
  localparam logic [7:0] OFF_EDGE  = 8'h18;
  localparam logic [7:0] OFF_GFLAG = 8'h1c;
  localparam logic [7:0] OFF_STAT  = 8'h20;

  localparam int GRP_FLAG_LSB = 4;
  localparam int GRP_EN_LSB   = 0;
  localparam int CTRL_GIE_BIT = 0;
  localparam int CTRL_PEN_LSB = 4;
  localparam int GFLAG_EN_LSB = 4;

  localparam logic [7:0] GRP_MASK = 8'h77;
  localparam logic [7:0] RST_BYTE = 8'h00;

  localparam logic [1:0] EDGE_OFF  = 2'h0;
  localparam logic [1:0] EDGE_RISE = 2'h1;
  localparam logic [1:0] EDGE_FALL = 2'h2;
  localparam logic [1:0] EDGE_BOTH = 2'h3;

  typedef struct packed {
    logic [PC_W-1:0] pc_next;
    logic            stack_full;
    logic            return_from_interrupt_instruction;
    logic            sleeping;
  } core_in_t;

  typedef struct packed {
    logic            take;
    logic            push;
    logic [PC_W-1:0] push_data;
    logic [PC_W-1:0] load_pc;
    logic            pop;
    logic            wake;
  } core_out_t;

endpackage : irq_vec_pkg

// *** sim/irq_vec_chk.sv ***
// Purpose: Concurrent checks on the ports of the vectoring block.
// Assumes: One clock domain, reset active low.
// Notes:   Bound into every instance of the block.
`timescale 1ns/1ps
module irq_vec_chk
  import irq_vec_pkg::*;
(
  input wire logic              pclk,
  input wire logic              presetn,
  input wire logic [N_PINS-1:0] pin_pullup_select,
  input wire logic [N_PINS-1:0] pin_pullup_enable,
  input core_in_t               core_in,
  input core_out_t              core_out
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_take_push:
    assert property (core_out.take |-> core_out.push) else $error("take without push");
  a_push_data:
    assert property (core_out.take |-> core_out.push_data == $past(core_in.pc_next))
    else $error("pushed address is not the next pc");
  a_pop_delay:
    assert property (core_in.return_from_interrupt_instruction |=> core_out.pop) else $error("return gave no pop");
  a_pop_cause:
    assert property (core_out.pop |-> $past(core_in.return_from_interrupt_instruction)) else $error("pop without return");
  a_take_once:
    assert property (core_out.take |=> !core_out.take) else $error("nested take");
  a_full_hold:
    assert property (core_in.stack_full |=> !core_out.take) else $error("take on full stack");
  a_take_room:
    assert property (core_out.take |-> !$past(core_in.stack_full))
    else $error("take decided while stack was full");
  a_pullup_kept:
    assert property (pin_pullup_enable == $past(pin_pullup_select))
    else $error("pull-up selection lost");
  a_wake_sleep:
    assert property (core_out.wake |-> $past(core_in.sleeping)) else $error("wake while awake");
endmodule : irq_vec_chk

bind irq_vec irq_vec_chk chk_i (
  .pclk(pclk),
  .presetn(presetn),
  .pin_pullup_select(pin_pullup_select),
  .pin_pullup_enable(pin_pullup_enable),
  .core_in(core_in),
  .core_out(core_out)
);

// *** sim/irq_core_model.sv ***
// Purpose: Core model with program counter and a shallow return stack.
// Assumes: Push and pop arrive as one-cycle pulses.
// Notes:   A one-entry stack makes the full case easy to reach.
`timescale 1ns/1ps
module irq_core_model
  import irq_vec_pkg::*;
#(
  parameter int DEPTH = 1
) (
  input wire logic pclk,
  input wire logic presetn,
  input core_out_t core_out,
  input wire logic do_return_from_interrupt_instruction,
  input wire logic sleep,
  output core_in_t core_in
);
  logic [PC_W-1:0] pc_q;
  logic [PC_W-1:0] saved_q;
  int              depth_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pc_q <= 13'h0100;
      saved_q <= 13'h0000;
      depth_q <= 0;
    end else if (core_out.push) begin
      saved_q <= core_out.push_data;
      pc_q <= core_out.load_pc;
      depth_q <= depth_q + 1;
    end else if (core_out.pop) begin
      pc_q <= saved_q;
      depth_q <= depth_q - 1;
    end else begin
      pc_q <= pc_q + 13'h0001;
    end
  end
  assign core_in = '{pc_q, depth_q >= DEPTH, do_return_from_interrupt_instruction, sleep};
endmodule : irq_core_model

// *** sim/test_interrupt_request_vectoring.sv ***
// Purpose: Register, service, priority, pin edge and wake tests.
// Assumes: Zero-wait APB slave; vectors at 4 plus 4 per index.
// Notes:   The take and load_pc outputs are sampled on the falling edge to avoid races.
`timescale 1ns/1ps
module test_interrupt_request_vectoring
  import irq_vec_pkg::*;
;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic pready, pslverr, err, do_return_from_interrupt_instruction = 1'b0, sleep = 1'b0;
  logic [7:0] paddr = 8'h00, q;
  logic [31:0] pwdata = 32'h0, prdata;
  logic [3:0] pins = 4'h0, dir = 4'hf, pus = 4'h0, pue;
  logic [11:0] ev = 12'h000;
  core_in_t core_in;
  core_out_t core_out;
  int mismatches = 0, tests_run = 0, cyc = 0, wakes = 0;
  always #20 pclk = ~pclk;
  always @(posedge pclk) begin
    cyc++;
    if (core_out.wake === 1'b1) wakes++;
    if (cyc == 20000) begin
      mismatches++;
      print_verdict();
    end
  end
  irq_vec dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .external_interrupt_pins(pins), .pin_func_is_irq(4'hf),
    .pin_dir_is_input(dir), .pin_pullup_select(pus), .pin_pullup_enable(pue),
    .member_events(ev), .core_in(core_in), .core_out(core_out));
  irq_core_model model (.pclk(pclk), .presetn(presetn), .core_out(core_out),
    .do_return_from_interrupt_instruction(do_return_from_interrupt_instruction), .sleep(sleep), .core_in(core_in));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata[7:0];
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    apb(1'b0, a, 8'h00);
    chk(q, exp);
  endtask : rd
  task automatic pulse(input int b);
    ev[b] <= 1'b1;
    @(posedge pclk);
    ev <= 12'h000;
    @(posedge pclk);
  endtask : pulse
  task automatic ret();
    do_return_from_interrupt_instruction <= 1'b1;
    @(posedge pclk);
    do_return_from_interrupt_instruction <= 1'b0;
    @(posedge pclk);
  endtask : ret
  task automatic wait_take(input logic [PC_W-1:0] exp);
    int n;
    n = 0;
    do begin @(negedge pclk); n++; end while (core_out.take !== 1'b1 && n < 20);
    chk({core_out.take, core_out.load_pc}, {1'b1, exp});
    @(posedge pclk);
  endtask : wait_take
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : print_verdict
  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    for (int i = 0; i < 9; i++) rd(8'(4 * i), 8'h00);
    chk(err, 1'b0);
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, 8'(4 * i), 8'hff);
      rd(8'(4 * i), GRP_MASK);
      apb(1'b1, 8'(4 * i), 8'h00);
    end
    rd(8'h40, 8'h00);
    chk(err, 1'b1);
    for (int b = 0; b < 12; b++) begin
      pulse(b);
      rd(8'(4 * (b / 3)), 8'h10 << (b % 3));
      apb(1'b1, 8'(4 * (b / 3)), 8'h00);
    end
    rd(OFF_GFLAG, 8'h00);
    $display("test registers done");
    apb(1'b1, OFF_GFLAG, 8'hf0);
    apb(1'b1, OFF_GRP2, 8'h01);
    apb(1'b1, OFF_CTRL, 8'h01);
    pulse(6);
    wait_take(13'h001c);
    rd(OFF_GRP2, 8'h11);
    rd(OFF_GFLAG, 8'hf0);
    rd(OFF_CTRL, 8'h00);
    ret();
    apb(1'b1, OFF_EDGE, 8'h01);
    apb(1'b1, OFF_CTRL, 8'h10);
    apb(1'b1, OFF_GRP0, 8'h01);
    pins <= 4'h1;
    pulse(0);
    repeat (4) begin @(negedge pclk); chk(core_out.take, 1'b0); end
    @(posedge pclk);
    rd(OFF_PFLAG, 8'h01);
    rd(OFF_GFLAG, 8'hf1);
    rd(OFF_STAT, 8'h10);
    apb(1'b1, OFF_CTRL, 8'h11);
    wait_take(13'h0004);
    rd(OFF_PFLAG, 8'h00);
    apb(1'b1, OFF_CTRL, 8'h11);
    repeat (10) begin @(negedge pclk); chk(core_out.take, 1'b0); end
    @(posedge pclk);
    ret();
    wait_take(13'h0014);
    ret();
    $display("test service done");
    for (int m = 0; m < 4; m++) begin
      apb(1'b1, OFF_EDGE, 8'(m << 2));
      pins[1] <= 1'b1;
      repeat (5) @(posedge pclk);
      rd(OFF_PFLAG, {6'h0, m[0], 1'b0});
      apb(1'b1, OFF_PFLAG, 8'h00);
      pins[1] <= 1'b0;
      repeat (5) @(posedge pclk);
      rd(OFF_PFLAG, {6'h0, m[1], 1'b0});
      apb(1'b1, OFF_PFLAG, 8'h00);
    end
    dir <= 4'hd;
    pins[1] <= 1'b1;
    repeat (5) @(posedge pclk);
    rd(OFF_PFLAG, 8'h00);
    $display("test pins done");
    sleep <= 1'b1;
    pus <= 4'hf;
    pulse(9);
    repeat (3) @(posedge pclk);
    chk(wakes, 1);
    chk(pue, 4'hf);
    apb(1'b1, OFF_GRP3, 8'h20);
    pulse(10);
    repeat (3) @(posedge pclk);
    chk(wakes, 1);
    $display("test wake done");
    print_verdict();
  end
endmodule : test_interrupt_request_vectoring
